// ==== rtl/adc_control_summation_regs.sv ====
// converter control registers and 32-bit summation/shifter engine
`include "adc_regs_cfg.svh"
module adc_control_summation_regs
    import adc_regs_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire sfr_req_t     i_sfr,
    input  wire logic [23:0]  i_result,
    input  wire logic         i_result_valid,
    input  wire logic         i_adc_powered,
    output logic [7:0]        o_rdata,
    output analog_ctrl_t      o_ctl,
    output logic              o_cal_start,
    output logic [2:0]        o_cal_mode,
    output logic              o_adc_irq,
    output logic              o_sum_irq
);
    state_t q, d;
    logic        wr_ss;
    logic [31:0] res_ext;
    logic [31:0] sext_stage;
    logic [8:0]  target_n;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        d = q;
        d.cal_start = 1'b0;
        res_ext = q.ctl.result_polarity ? {8'h00, i_result} : {{8{i_result[23]}}, i_result};
        sext_stage = q.stage;
        target_n = 9'h002 << q.scnt;
        // a summation control write wins over an engine step in the same cycle
        wr_ss = i_sfr.wr && i_sfr.addr == `ADDR_SSCTRL;
        if (i_sfr.rd && i_sfr.addr == `ADDR_RES_LO) begin
            d.adc_irq = 1'b0;
        end
        if (i_result_valid) begin
            d.adc_irq = 1'b1;
            d.res     = i_result;
        end
        if (i_sfr.rd && i_sfr.addr == `ADDR_SUM0) begin
            d.sum_irq = 1'b0;
        end
        // read path, bits above fields read zero
        unique case (i_sfr.addr)
            `ADDR_RES_LO:  d.rdata = q.res[7:0];
            `ADDR_RES_MID: d.rdata = q.res[15:8];
            `ADDR_RES_HI:  d.rdata = q.res[23:16];
            `ADDR_ACTRL:   d.rdata = {1'b0, q.ctl.burnout_current_enable, q.ctl.internal_reference_enable,
                                      q.ctl.reference_level_select, q.ctl.input_buffer_enable, q.ctl.gain_select};
            `ADDR_PFC:     d.rdata = {1'b0, q.ctl.result_polarity, q.ctl.settling_mode, 4'h0};
            `ADDR_DEC_LO:  d.rdata = q.ctl.decimation_ratio[7:0];
            `ADDR_DEC_HI:  d.rdata = {5'h00, q.ctl.decimation_ratio[10:8]};
            `ADDR_SSCTRL:  d.rdata = {q.mode, q.scnt, q.shf};
            `ADDR_SUM0:    d.rdata = q.sum[7:0];
            `ADDR_SUM1:    d.rdata = q.sum[15:8];
            `ADDR_SUM2:    d.rdata = q.sum[23:16];
            `ADDR_SUM3:    d.rdata = q.sum[31:24];
            default:       d.rdata = 8'h00;
        endcase
        if (i_sfr.wr) begin
            unique case (i_sfr.addr)
                `ADDR_ACTRL: begin
                    d.ctl.burnout_current_enable    = i_sfr.wdata[6];
                    d.ctl.internal_reference_enable = i_sfr.wdata[5];
                    d.ctl.reference_level_select    = i_sfr.wdata[4];
                    d.ctl.input_buffer_enable       = i_sfr.wdata[3];
                    d.ctl.gain_select               = i_sfr.wdata[2:0];
                end
                `ADDR_PFC: begin
                    d.ctl.result_polarity = i_sfr.wdata[6];
                    d.ctl.settling_mode   = i_sfr.wdata[5:4];
                    if (i_sfr.wdata[2:0] != 3'h0 && i_sfr.wdata[2:0] < `CAL_RSV_MIN) begin
                        d.cal_start = 1'b1;
                        d.cal_mode  = i_sfr.wdata[2:0];
                    end
                end
                `ADDR_DEC_LO: d.ctl.decimation_ratio[7:0]  = i_sfr.wdata;
                `ADDR_DEC_HI: d.ctl.decimation_ratio[10:8] = i_sfr.wdata[2:0];
                `ADDR_SSCTRL: begin
                    d.mode  = sum_mode_t'(i_sfr.wdata[7:6]);
                    d.scnt  = i_sfr.wdata[5:3];
                    d.shf   = i_sfr.wdata[2:0];
                    d.acc_n = 9'h000;
                    d.st    = ST_IDLE;
                    if (i_sfr.wdata == 8'h00) begin
                        d.sum = 32'h00000000;
                    end else if (sum_mode_t'(i_sfr.wdata[7:6]) == SRC_CPU_SHIFT) begin
                        d.st      = ST_SHIFT;
                        d.shf_cyc = 3'h1;
                    end
                end
                `ADDR_SUM1: d.stage[15:8]  = i_sfr.wdata;
                `ADDR_SUM2: d.stage[23:16] = i_sfr.wdata;
                `ADDR_SUM3: d.stage[31:24] = i_sfr.wdata;
                `ADDR_SUM0: begin
                    d.stage[7:0] = i_sfr.wdata;
                    sext_stage   = {q.stage[31:8], i_sfr.wdata};
                    if (q.mode == SRC_CPU_ADD) begin
                        d.sum = q.sum + sext_stage;
                    end
                end
                default: ;
            endcase
        end
        // adc-fed summation
        if (i_result_valid && q.st == ST_IDLE && !wr_ss &&
            (q.mode == SRC_ADC_SUM || q.mode == SRC_ADC_SHIFT)) begin
            d.sum   = q.sum + res_ext;
            d.acc_n = q.acc_n + 9'h001;
            if (q.acc_n + 9'h001 == target_n) begin
                d.acc_n = 9'h000;
                if (q.mode == SRC_ADC_SHIFT) begin
                    d.st      = ST_SHIFT;
                    d.shf_cyc = 3'h1;
                end else begin
                    d.sum_irq = 1'b1;
                end
            end
        end
        // shift takes four clocks, result lands on the last
        if (q.st == ST_SHIFT && !wr_ss) begin
            if (q.shf_cyc == `SHIFT_CYCLES - 3'h1) begin
                d.sum = q.ctl.result_polarity ? (q.sum >> ({2'h0, q.shf} + 5'h01))
                                              : 32'($signed(q.sum) >>> ({2'h0, q.shf} + 5'h01));
                d.st      = ST_IDLE;
                d.sum_irq = 1'b1;
            end else begin
                d.shf_cyc = q.shf_cyc + 3'h1;
            end
        end
        if (!i_adc_powered) begin
            d.sum   = 32'h00000000;
            d.acc_n = 9'h000;
            d.st    = ST_IDLE;
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
            {q.ctl.burnout_current_enable, q.ctl.internal_reference_enable, q.ctl.reference_level_select,
             q.ctl.input_buffer_enable, q.ctl.gain_select} <= 7'(`RST_ACTRL & `ACTRL_MASK);
            q.ctl.decimation_ratio <= {`RST_DEC_HI, `RST_DEC_LO};
            q.mode <= SRC_CPU_ADD;
            q.st   <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign o_rdata     = q.rdata;
    assign o_ctl       = q.ctl;
    assign o_cal_start = q.cal_start;
    assign o_cal_mode  = q.cal_mode;
    assign o_adc_irq   = q.adc_irq;
    assign o_sum_irq   = q.sum_irq;
endmodule

// ==== rtl/adc_regs_cfg.svh ====
// constants for the converter control and summation register bank
// Functional notes
// - 24-bit result in three bytes; reading low byte clears conversion interrupt.
// - burnout bit 6 turns on channel source currents; off at reset.
// - reference enable defaults on; level select 0 is 1.25V, 1 is 2.5V.
// - input buffer enable output follows its bit; disabled at reset.
// - gain field bits 2-0 selects gain two to the field value.
// - polarity bit governs result and sum: bipolar or clamped unipolar.
// - settling field bits 5-4: auto, fast, sinc2, sinc3.
// - writing calibration codes 1-5 starts calibration; field always reads zero.
// - 11-bit decimation ratio split in low byte and three upper bits.
// - summation logic powered down while converter is powered down.
// - writing zero to summation control clears the whole 32-bit sum.
// - bipolar polarity sign-extends values entering the sum.
// - mode bits 7-6: cpu add, adc sum, cpu shift, adc sum then shift.
// - cpu add mode adds written sum bytes when byte zero is written.
// - shift mode shifts right by shift count plus one, done in four clocks.
// - accumulate-and-shift sums the count of results then shifts.
// - summation count field selects 2 to 256 results; completion interrupts.
// - shift count field shifts right by field plus one bits.
// - sum exposed as four bytes, byte zero holding bits 7-0.
// - reading sum byte zero clears completion interrupt; software clears flag.
// - upper sum bytes hold bits 15-8, 23-16, 31-24; reset zero.
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH
`define ADDR_RES_LO      8'hD9
`define ADDR_RES_MID     8'hDA
`define ADDR_RES_HI      8'hDB
`define ADDR_ACTRL       8'hDC
`define ADDR_PFC         8'hDD
`define ADDR_DEC_LO      8'hDE
`define ADDR_DEC_HI      8'hDF
`define ADDR_SSCTRL      8'hE1
`define ADDR_SUM0        8'hE2
`define ADDR_SUM1        8'hE3
`define ADDR_SUM2        8'hE4
`define ADDR_SUM3        8'hE5
`define RST_ACTRL        8'h30
`define RST_PFC          8'h00
`define RST_DEC_LO       8'h1B
`define RST_DEC_HI       3'h6
`define RST_SSCTRL       8'h00
`define ACTRL_MASK       8'h7F
`define PFC_MASK         8'h70
`define CAL_RSV_MIN      3'h6
`define SHIFT_CYCLES     3'h4
`endif

// ==== rtl/adc_regs_pkg.sv ====
// types for the converter control and summation register bank
package adc_regs_pkg;
    typedef enum logic [1:0] {
        SRC_CPU_ADD   = 2'h0,
        SRC_ADC_SUM   = 2'h1,
        SRC_CPU_SHIFT = 2'h2,
        SRC_ADC_SHIFT = 2'h3
    } sum_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SHIFT = 2'h1
    } sum_state_t;

    typedef struct packed {
        logic       burnout_current_enable;
        logic       internal_reference_enable;
        logic       reference_level_select;
        logic       input_buffer_enable;
        logic [2:0] gain_select;
        logic       result_polarity;
        logic [1:0] settling_mode;
        logic [10:0] decimation_ratio;
    } analog_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        analog_ctrl_t ctl;
        sum_mode_t    mode;
        logic [2:0]   scnt;
        logic [2:0]   shf;
        logic [31:0]  sum;
        logic [31:0]  stage;
        logic [8:0]   acc_n;
        sum_state_t   st;
        logic [2:0]   shf_cyc;
        logic         adc_irq;
        logic         sum_irq;
        logic         cal_start;
        logic [2:0]   cal_mode;
        logic [23:0]  res;
        logic [7:0]   rdata;
    } state_t;
endpackage

// ==== test/adc_regs_props.sv ====
// assertions on the ports of the converter register bank
`include "adc_regs_cfg.svh"
module adc_regs_props
    import adc_regs_pkg::*;
(
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    input wire sfr_req_t     i_sfr,
    input wire logic [23:0]  i_result,
    input wire logic         i_result_valid,
    input wire logic         i_adc_powered,
    input wire logic [7:0]   o_rdata,
    input wire analog_ctrl_t o_ctl,
    input wire logic         o_cal_start,
    input wire logic [2:0]   o_cal_mode,
    input wire logic         o_adc_irq,
    input wire logic         o_sum_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic w_pfc;
    assign w_pfc = i_sfr.wr && i_sfr.addr == `ADDR_PFC;
    sequence shift_go;
        i_sfr.wr && i_sfr.addr == `ADDR_SSCTRL && i_sfr.wdata[7:6] == 2'h2 && i_adc_powered;
    endsequence
    sequence clear_read;
        i_sfr.wr && i_sfr.addr == `ADDR_SSCTRL && i_sfr.wdata == 8'h00
        ##1 !i_sfr.wr && i_sfr.addr inside {[`ADDR_SUM0:`ADDR_SUM3]};
    endsequence
    // quiet window so no completion can race the clearing read
    sequence quiet_read;
        (!i_sfr.wr && !i_result_valid)[*5] ##0 (i_sfr.rd && i_sfr.addr == `ADDR_SUM0);
    endsequence
    a_adc_irq_set: assert property (i_result_valid |=> o_adc_irq) else $error("conversion irq missing");
    a_adc_irq_clear: assert property (
        i_sfr.rd && i_sfr.addr == `ADDR_RES_LO && !i_result_valid |=> !o_adc_irq) else $error("irq not cleared");
    a_cal_start: assert property (
        w_pfc && i_sfr.wdata[2:0] inside {[3'h1:3'h5]} |=> o_cal_start && o_cal_mode == $past(i_sfr.wdata[2:0]))
        else $error("calibration not started");
    a_cal_reserved: assert property (
        w_pfc && i_sfr.wdata[2:0] >= `CAL_RSV_MIN |=> !o_cal_start && $stable(o_cal_mode)) else $error("reserved cal");
    a_ctl_follow: assert property (
        i_sfr.wr && i_sfr.addr == `ADDR_ACTRL |=> o_ctl[20:14] == $past(i_sfr.wdata[6:0])) else $error("ctl mismatch");
    a_sum_clear: assert property (clear_read |=> o_rdata == 8'h00) else $error("sum not cleared");
    a_shift_time: assert property (
        shift_go ##1 (!i_sfr.wr && i_adc_powered)[*3] |=> o_sum_irq) else $error("shift not done in time");
    a_sum_irq_clear: assert property (quiet_read |=> !o_sum_irq) else $error("sum irq not cleared");
endmodule

bind adc_control_summation_regs adc_regs_props chk_u (.*);

// ==== test/adc_front_model.sv ====
// behavioural converter front end handing conversion words to the bank
module adc_front_model
    import adc_regs_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire analog_ctrl_t i_ctl,
    input  wire logic         i_fire,
    input  wire logic [23:0]  i_level,
    output logic [23:0]       o_result,
    output logic              o_result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_clk) begin
        o_result_valid <= i_fire && i_rst_n;
        if (!i_rst_n)
            o_result <= 24'h000000;
        else if (i_fire && i_ctl.result_polarity)
            o_result <= i_level[23] ? 24'h000000 : {i_level[22:0], 1'b0};
        else if (i_fire)
            o_result <= i_level;
        // word is inverted every clock between conversions
        else
            o_result <= ~o_result;
    end
endmodule

// ==== test/adc_control_summation_regs_tb_top.sv ====
// self-checking bench for the converter register bank
`include "adc_regs_cfg.svh"
module adc_control_summation_regs_tb_top
    import adc_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, rst_n, pwr, vld, fire, cs, airq, sirq, rd_q;
    logic [2:0]   cm;
    logic [7:0]   rdata, eq[$];
    logic [23:0]  res, lvl;
    logic [31:0]  lf, sm;
    sfr_req_t     sfr;
    analog_ctrl_t ctl;
    int           errors, checked, cyc;
    adc_control_summation_regs dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_sfr(sfr), .i_result(res),
        .i_result_valid(vld), .i_adc_powered(pwr), .o_rdata(rdata), .o_ctl(ctl), .o_cal_start(cs),
        .o_cal_mode(cm), .o_adc_irq(airq), .o_sum_irq(sirq));
    adc_front_model model_u (.i_clk(clk), .i_rst_n(rst_n), .i_ctl(ctl), .i_fire(fire), .i_level(lvl),
        .o_result(res), .o_result_valid(vld));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up();
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // strobes stay up until the next op, so every burst ends in idle
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        eq.push_back(e);
        op(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic rd_sum();
        for (int i = 0; i < 4; i++) rd(`ADDR_SUM0 + 8'(i), sm[8*i+:8]);
        idle(1);
    endtask
    task automatic conv(input logic [23:0] c);
        @(posedge clk);
        fire <= 1'b1;
        lvl <= c;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rd_q) cmp(rdata, eq.pop_front());
        rd_q <= sfr.rd;
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, pwr, fire, rd_q, lvl, sfr, sm} = '0;
        pwr = 1'b1;
        lf = 32'h79D6188E;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1 cmp(ctl, {7'h30, 3'h0, 11'h61B});
        rd(`ADDR_ACTRL, `RST_ACTRL);
        rd(`ADDR_DEC_LO, `RST_DEC_LO);
        rd(`ADDR_SSCTRL, 8'h00);
        wr(`ADDR_RES_MID, 8'hFF);
        rd(`ADDR_RES_MID, 8'h00);
        rd(8'hE0, 8'h00);
        rd_sum();
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            wr(`ADDR_ACTRL, lf[7:0]);
            wr(`ADDR_DEC_LO, lf[15:8]);
            wr(`ADDR_DEC_HI, lf[23:16]);
            rd(`ADDR_ACTRL, lf[7:0] & `ACTRL_MASK);
            idle(1);
            #1 cmp({ctl[20:14], ctl[10:0]}, {lf[6:0], lf[18:16], lf[15:8]});
        end
        for (int c = 0; c < 8; c++) begin
            wr(`ADDR_PFC, {1'b0, c[0], c[1:0], 1'b0, c[2:0]});
            idle(1);
            #1 cmp(cs, c inside {[1:5]});
            cmp(cm, (c > 5) ? 3'h5 : 3'(c));
            cmp(ctl[13:11], {c[0], c[1:0]});
            rd(`ADDR_PFC, {1'b0, c[0], c[1:0], 4'h0});
        end
        wr(`ADDR_PFC, 8'h00);
        idle(1);
        lf = nxt(lf);
        conv(lf[23:0]);
        idle(2);
        #1 cmp(airq, 1'b1);
        rd(`ADDR_RES_HI, lf[23:16]);
        rd(`ADDR_RES_MID, lf[15:8]);
        rd(`ADDR_RES_LO, lf[7:0]);
        idle(2);
        #1 cmp(airq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            lf = nxt(lf) | 32'h80000000;
            for (int b = 3; b >= 0; b--) wr(`ADDR_SUM0 + 8'(b), lf[8*b+:8]);
            sm = sm + lf;
        end
        idle(1);
        rd_sum();
        wr(`ADDR_SSCTRL, {5'h10, lf[2:0]});
        sm = $signed(sm) >>> (lf[2:0] + 1);
        idle(5);
        #1 cmp(sirq, 1'b1);
        rd_sum();
        idle(1);
        #1 cmp(sirq, 1'b0);
        for (int m = 1; m < 6; m += 2) begin
            // unipolar pass zero-extends and counts four results
            if (m == 5) wr(`ADDR_PFC, 8'h40);
            wr(`ADDR_SSCTRL, 8'h00);
            sm = '0;
            rd_sum();
            wr(`ADDR_SSCTRL, {m[1:0], 2'h0, m[2], 3'h0});
            idle(1);
            for (int k = 0; k < 2 + 2 * m[2]; k++) begin
                lf = nxt(lf);
                conv({m != 5, lf[22:0]});
                sm = sm + ((m == 5) ? {8'h00, lf[22:0], 1'b0} : {9'h1FF, lf[22:0]});
            end
            if (m == 3) sm = $signed(sm) >>> 1;
            idle(7);
            #1 cmp(sirq, 1'b1);
            rd_sum();
        end
        pwr <= 1'b0;
        idle(2);
        pwr <= 1'b1;
        sm = '0;
        rd_sum();
        idle(2);
        wrap_up();
    end
endmodule
